// ==== core/l2_cache_pkg.sv ====
// Package for the secondary cache fill and SRAM control block.
// Assumes one clock domain and a simple strobe register port.
package l2_cache_pkg;
    localparam logic [7:0] SHADOW_CACHE_CONTROL_OFS = 8'h18;
    localparam logic [7:0] CACHE_FILL_CONFIG_OFS = 8'h22;
    localparam logic [7:0] MEMORY_DECODE_A_OFS = 8'h33;
    localparam logic [7:0] MEMORY_DECODE_B_OFS = 8'h37;
    localparam logic [7:0] SMM_CONTROL_OFS = 8'h94;
    localparam logic [7:0] CACHE_MODE_OFS = 8'hA0;
    localparam logic [7:0] CACHE_STATUS_OFS = 8'hA1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int SHADOW_EN_BIT = 2;
    localparam int SHADOW_L2_BIT = 3;
    localparam int WPROT_BIT = 7;
    localparam int DEC_L1_BIT0 = 0;
    localparam int DEC_L1_BIT1 = 1;
    localparam int SMM_BIT = 3;
    localparam int FILL_POL_LO = 6;
    localparam int DUAL_BANK_BIT = 0;
    localparam int CS_HIGH_BIT = 1;
    localparam int WB_MODE_BIT = 2;
    localparam int TAGW_LO = 3;
    localparam int CSIZE_LO = 5;
    localparam logic [1:0] TAGW_8 = 2'h0;
    localparam logic [1:0] TAGW_9 = 2'h1;
    localparam logic [1:0] TAGW_11 = 2'h2;
    localparam int DRAM_MAX_BIT = 27;
    localparam int BEATS = 4;
    typedef enum logic [1:0] {
        POL_UNIFIED,
        POL_CODE,
        POL_DATA,
        POL_RSVD
    } fill_pol_t;
endpackage

// ==== core/l2_cache_fill_and_sram_ctrl.sv ====
// Secondary cache cacheability decisions and data SRAM strobe control.
// Assumes synchronous CPU bus inputs, an external tag compare feeding tagHit.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
module l2_cache_fill_and_sram_ctrl #(
    parameter int ADDR_W = 28
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic cycStart,
    input wire logic [31:0] cpuAddr,
    input wire logic memCycle,
    input wire logic writeCycle,
    input wire logic dataCode,
    input wire logic smmActive,
    input wire logic localDram,
    input wire logic shadowArea,
    input wire logic decodeHitA,
    input wire logic decodeHitB,
    input wire logic tagHit,
    input wire logic tagDirty,
    input wire logic beatDone,
    output logic l1FillEnable_n,
    output logic l2Hit,
    output logic l2Fill,
    output logic castout,
    output logic sram_addr_bit2,
    output logic sram_addr_bit3A,
    output logic sram_addr_bit3B,
    output logic sram_output_enable_nA,
    output logic sram_output_enable_nB,
    output logic sram_write_enable_nA,
    output logic sram_write_enable_nB,
    output logic sram_chip_select
);
    if (ADDR_W < 24 || ADDR_W > 32) begin : g_addr_w_check
        $error("ADDR_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BURST
    } phase_t;

    typedef struct packed {
        logic [7:0] shadowCtl;
        logic [7:0] fillCfg;
        logic [7:0] decA;
        logic [7:0] decB;
        logic [7:0] smmCtl;
        logic [7:0] mode;
        logic [7:0] rdata;
        phase_t phase;
        logic [1:0] beat;
        logic isWrite;
        logic hit;
        logic fill;
        logic cast;
        logic kenN;
        logic a2;
        logic a3a;
        logic a3b;
        logic oeA;
        logic oeB;
        logic weA;
        logic weB;
        logic cs;
    } state_t;

    state_t stateReg;
    state_t stateNext;

    ////////////////////////////////////////////////////////////////////////
    // Highest tagged address bit; everything above must be zero for L2.
    logic [4:0] topBit;
    logic [2:0] csize;
    logic [1:0] tagw;
    logic [4:0] base;
    logic inRange;
    logic l2Elig;
    logic l1Elig;
    logic polOk;
    logic wprot;
    logic wbMode;
    logic dual;
    logic [1:0] startWord;
    l2_cache_pkg::fill_pol_t pol;

    always_comb begin
        csize = stateReg.mode[l2_cache_pkg::CSIZE_LO +: 3];
        tagw = stateReg.mode[l2_cache_pkg::TAGW_LO +: 2];
        dual = stateReg.mode[l2_cache_pkg::DUAL_BANK_BIT];
        wbMode = stateReg.mode[l2_cache_pkg::WB_MODE_BIT];
        // Line select top is A15 for 64K; dirty bit costs one tag bit in WB.
        base = 5'(15 + (csize > 3'h4 ? 3'h4 : csize));
        case (tagw)
            l2_cache_pkg::TAGW_9: topBit = 5'(base + 5'h8);
            l2_cache_pkg::TAGW_11: topBit = 5'(base + 5'hA);
            default: topBit = 5'(base + 5'h7);
        endcase
        if (!wbMode) begin
            topBit = 5'(topBit + 5'h1);
        end
        if (topBit > 5'(l2_cache_pkg::DRAM_MAX_BIT)) begin
            topBit = 5'(l2_cache_pkg::DRAM_MAX_BIT);
        end
        inRange = ((cpuAddr >> (topBit + 5'h1)) == 32'h0000_0000);
    end

    always_comb begin
        pol = l2_cache_pkg::fill_pol_t'(stateReg.fillCfg[l2_cache_pkg::FILL_POL_LO +: 2]);
        wprot = stateReg.shadowCtl[l2_cache_pkg::WPROT_BIT] && shadowArea;
        case (pol)
            l2_cache_pkg::POL_CODE: polOk = !dataCode;
            l2_cache_pkg::POL_DATA: polOk = dataCode;
            default: polOk = 1'b1;
        endcase
        l2Elig = localDram && inRange && (!shadowArea || stateReg.shadowCtl[l2_cache_pkg::SHADOW_L2_BIT]);
        l1Elig = (localDram && (!shadowArea || stateReg.shadowCtl[l2_cache_pkg::SHADOW_EN_BIT]) && !wprot)
            || (decodeHitA && (stateReg.decA[l2_cache_pkg::DEC_L1_BIT0] || stateReg.decA[l2_cache_pkg::DEC_L1_BIT1]))
            || (decodeHitB && (stateReg.decB[l2_cache_pkg::DEC_L1_BIT0] || stateReg.decB[l2_cache_pkg::DEC_L1_BIT1]));
        if (smmActive && !stateReg.smmCtl[l2_cache_pkg::SMM_BIT]) begin
            l1Elig = 1'b0;
        end
        startWord = cpuAddr[3:2];
    end

    ////////////////////////////////////////////////////////////////////////
    logic csOn;
    logic csOff;
    logic [1:0] wordNow;
    logic [1:0] wordNext;

    always_comb begin
        stateNext = stateReg;
        csOn = stateReg.mode[l2_cache_pkg::CS_HIGH_BIT];
        csOff = !csOn;
        wordNow = 2'(startWord ^ stateReg.beat);
        wordNext = 2'(startWord ^ 2'(stateReg.beat + 2'h1));
        stateNext.rdata = 8'h00;
        if (regRd) begin
            case (regAddr)
                l2_cache_pkg::SHADOW_CACHE_CONTROL_OFS: stateNext.rdata = stateReg.shadowCtl;
                l2_cache_pkg::CACHE_FILL_CONFIG_OFS: stateNext.rdata = stateReg.fillCfg;
                l2_cache_pkg::MEMORY_DECODE_A_OFS: stateNext.rdata = stateReg.decA;
                l2_cache_pkg::MEMORY_DECODE_B_OFS: stateNext.rdata = stateReg.decB;
                l2_cache_pkg::SMM_CONTROL_OFS: stateNext.rdata = stateReg.smmCtl;
                l2_cache_pkg::CACHE_MODE_OFS: stateNext.rdata = stateReg.mode;
                l2_cache_pkg::CACHE_STATUS_OFS: stateNext.rdata = {3'h0, stateReg.kenN, stateReg.cast,
                    stateReg.fill, stateReg.hit, stateReg.phase == ST_BURST};
                default: stateNext.rdata = 8'h00;
            endcase
        end
        if (regWr) begin
            case (regAddr)
                l2_cache_pkg::SHADOW_CACHE_CONTROL_OFS: stateNext.shadowCtl = regWdata;
                l2_cache_pkg::CACHE_FILL_CONFIG_OFS: stateNext.fillCfg = regWdata;
                l2_cache_pkg::MEMORY_DECODE_A_OFS: stateNext.decA = regWdata;
                l2_cache_pkg::MEMORY_DECODE_B_OFS: stateNext.decB = regWdata;
                l2_cache_pkg::SMM_CONTROL_OFS: stateNext.smmCtl = regWdata;
                l2_cache_pkg::CACHE_MODE_OFS: stateNext.mode = regWdata;
                default: ;
            endcase
        end
        case (stateReg.phase)
            ST_IDLE: begin
                stateNext.kenN = 1'b1;
                stateNext.oeA = 1'b1;
                stateNext.oeB = 1'b1;
                stateNext.weA = 1'b1;
                stateNext.weB = 1'b1;
                stateNext.cs = csOff;
                stateNext.hit = 1'b0;
                stateNext.fill = 1'b0;
                stateNext.cast = 1'b0;
                if (cycStart && memCycle) begin
                    stateNext.isWrite = writeCycle;
                    stateNext.kenN = !(l1Elig && !writeCycle);
                    // Hits ignore fill policy and the shadow L2 bit, but still need local DRAM in range.
                    stateNext.hit = tagHit && inRange && localDram;
                    stateNext.fill = !tagHit && !writeCycle && l2Elig && polOk;
                    stateNext.cast = !tagHit && !writeCycle && l2Elig && polOk && wbMode && tagDirty;
                    stateNext.beat = 2'h0;
                    if ((tagHit && inRange && localDram) || (!tagHit && !writeCycle && l2Elig && polOk)) begin
                        stateNext.phase = ST_BURST;
                        stateNext.cs = csOn;
                        stateNext.a2 = dual ? cpuAddr[base] : startWord[0];
                        stateNext.a3a = startWord[1];
                        stateNext.a3b = startWord[1];
                        if (!writeCycle) begin
                            stateNext.oeA = dual ? startWord[0] : 1'b0;
                            stateNext.oeB = dual ? !startWord[0] : 1'b1;
                        end else if (!wprot) begin
                            stateNext.weA = dual ? startWord[0] : 1'b0;
                            stateNext.weB = dual ? !startWord[0] : 1'b1;
                        end
                    end
                end
            end
            ST_BURST: begin
                if (beatDone) begin
                    stateNext.beat = 2'(stateReg.beat + 2'h1);
                    if (stateReg.isWrite || stateReg.beat == 2'(l2_cache_pkg::BEATS - 1)) begin
                        stateNext.phase = ST_IDLE;
                        stateNext.cs = csOff;
                        stateNext.oeA = 1'b1;
                        stateNext.oeB = 1'b1;
                        stateNext.weA = 1'b1;
                        stateNext.weB = 1'b1;
                        stateNext.hit = 1'b0;
                        stateNext.fill = 1'b0;
                        stateNext.cast = 1'b0;
                        stateNext.kenN = 1'b1;
                    end else if (dual) begin
                        // Only the bank just read moves its address bit 3, on to its word two
                        // beats ahead, so the other bank keeps a full beat of access time.
                        if (wordNow[0]) begin
                            stateNext.a3b = !wordNow[1];
                        end else begin
                            stateNext.a3a = !wordNow[1];
                        end
                        stateNext.oeA = wordNext[0];
                        stateNext.oeB = !wordNext[0];
                    end else begin
                        stateNext.a2 = wordNext[0];
                        stateNext.a3a = wordNext[1];
                    end
                end
            end
            default: stateNext.phase = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stateReg <= '0;
            stateReg.kenN <= 1'b1;
            stateReg.oeA <= 1'b1;
            stateReg.oeB <= 1'b1;
            stateReg.weA <= 1'b1;
            stateReg.weB <= 1'b1;
            stateReg.cs <= 1'b1;
            stateReg.phase <= ST_IDLE;
        end else if (clkEn) begin
            stateReg <= stateNext;
        end
    end

    assign regRdata = stateReg.rdata;
    assign l1FillEnable_n = stateReg.kenN;
    assign l2Hit = stateReg.hit;
    assign l2Fill = stateReg.fill;
    assign castout = stateReg.cast;
    assign sram_addr_bit2 = stateReg.a2;
    assign sram_addr_bit3A = stateReg.a3a;
    assign sram_addr_bit3B = stateReg.a3b;
    assign sram_output_enable_nA = stateReg.oeA;
    assign sram_output_enable_nB = stateReg.oeB;
    assign sram_write_enable_nA = stateReg.weA;
    assign sram_write_enable_nB = stateReg.weB;
    assign sram_chip_select = stateReg.cs;

    ////////////////////////////////////////////////////////////////////////
    // Most checks look one edge after a request is taken, at the registered decision.
    // Register writes during a burst are not guarded; software is expected to wait for idle.
    a_write_no_fill: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && memCycle && writeCycle |=> !l2Fill)
        else $error("write allocated a line");

    a_ken_idle_high: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && !cycStart |=> l1FillEnable_n)
        else $error("fill enable not high when idle");

    a_policy_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && memCycle
        && pol == l2_cache_pkg::POL_DATA && !dataCode |=> !l2Fill)
        else $error("data-only policy filled on code");

    a_code_only: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart
        && pol == l2_cache_pkg::POL_CODE && dataCode |=> !l2Fill)
        else $error("code-only policy filled on data");

    a_miss_no_cast: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && memCycle && !tagHit && !polOk
        |=> !castout && !l2Fill)
        else $error("excluded miss replaced a line");

    a_outside_dram: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && !localDram |=> !l2Fill && !l2Hit)
        else $error("non-DRAM cycle used L2");

    a_decode_l1_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && !localDram && decodeHitA && !decodeHitB
        && !stateReg.decA[l2_cache_pkg::DEC_L1_BIT0] && !stateReg.decA[l2_cache_pkg::DEC_L1_BIT1] |=> l1FillEnable_n)
        else $error("undecoded area made L1 cacheable");

    a_range_fill: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && !inRange |=> !l2Fill && !l2Hit)
        else $error("out of range cycle used L2");

    a_dram_l1_on: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && memCycle && localDram && !writeCycle
        && !shadowArea && !smmActive |=> !l1FillEnable_n)
        else $error("local DRAM read not L1 cacheable");

    a_write_ken: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && writeCycle |=> l1FillEnable_n)
        else $error("fill enable low on a write");

    a_smm_l1_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && smmActive
        && !stateReg.smmCtl[l2_cache_pkg::SMM_BIT] |=> l1FillEnable_n)
        else $error("fill enable low in SMM");

    a_shadow_l2_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && shadowArea
        && !stateReg.shadowCtl[l2_cache_pkg::SHADOW_L2_BIT] |=> !l2Fill)
        else $error("shadow fill with L2 shadow caching off");

    a_hit_any_pol: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && memCycle && tagHit && inRange && localDram |=> l2Hit)
        else $error("hit suppressed");

    a_wprot_no_we: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && stateReg.phase == ST_IDLE && cycStart && memCycle && writeCycle && wprot
        |=> sram_write_enable_nA && sram_write_enable_nB)
        else $error("write to protected shadow reached SRAM");

    a_cs_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && !regWr && stateReg.phase == ST_IDLE && !cycStart
        |=> sram_chip_select != stateReg.mode[l2_cache_pkg::CS_HIGH_BIT])
        else $error("chip select active while idle");

    a_single_oe_low: assert property (@(posedge sys_clk) disable iff (!nrst)
        !dual && stateReg.phase == ST_BURST && !stateReg.isWrite
        |-> !sram_output_enable_nA && sram_output_enable_nB && sram_write_enable_nB)
        else $error("single bank read strobes wrong");

    a_one_bank_oe: assert property (@(posedge sys_clk) disable iff (!nrst)
        dual && stateReg.phase == ST_BURST && !stateReg.isWrite |-> sram_output_enable_nA != sram_output_enable_nB)
        else $error("dual bank read strobes not exclusive");
endmodule

// ==== bench/cpu_bus_model.sv ====
// Far-side model of the CPU bus: answers each claimed cache cycle with beat pulses.
// Assumes busy is high while the block owns a cycle; slow stretches the wait between beats.
`timescale 1ns/1ns
module cpu_bus_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic busy,
    input wire logic slow,
    output logic beatDone
);
    logic [1:0] gapCnt;
    // At least one quiet cycle follows every beat, so the block can drop busy before another lands.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gapCnt <= 2'h0;
            beatDone <= 1'b0;
        end else if (beatDone || !busy) begin
            beatDone <= 1'b0;
            gapCnt <= slow ? 2'h3 : 2'h0;
        end else if (gapCnt != 2'h0) begin
            gapCnt <= gapCnt - 2'h1;
        end else begin
            beatDone <= 1'b1;
        end
    end
endmodule

// ==== bench/test_l2_cache_fill_and_sram_ctrl.sv ====
// Self-checking bench for the secondary cache fill and SRAM control block.
// Assumes the bus model answers beats; expected values come from the register settings.
`timescale 1ns/1ns
module test_l2_cache_fill_and_sram_ctrl;
    logic sys_clk, nrst, clkEn, regWr, regRd, cycStart, memCycle, writeCycle, dataCode, smmActive;
    logic localDram, shadowArea, decodeHitA, decodeHitB, tagHit, tagDirty, beatDone, slow, busy;
    logic l1FillEnable_n, l2Hit, l2Fill, castout, csBusy;
    logic sram_addr_bit2, sram_addr_bit3A, sram_addr_bit3B, sram_output_enable_nA, sram_output_enable_nB;
    logic sram_write_enable_nA, sram_write_enable_nB, sram_chip_select;
    logic [7:0] regAddr, regWdata, regRdata;
    logic [31:0] cpuAddr;
    logic [1:0] oeS [4];
    logic [1:0] weS [4];
    logic [2:0] adS [4];
    int failures, n_compared, nBeats;
    assign busy = l2Hit || l2Fill || castout;
    l2_cache_fill_and_sram_ctrl l2_cache_fill_and_sram_ctrl_inst (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .cycStart(cycStart), .cpuAddr(cpuAddr), .memCycle(memCycle), .writeCycle(writeCycle),
        .dataCode(dataCode), .smmActive(smmActive), .localDram(localDram), .shadowArea(shadowArea),
        .decodeHitA(decodeHitA), .decodeHitB(decodeHitB), .tagHit(tagHit), .tagDirty(tagDirty),
        .beatDone(beatDone), .l1FillEnable_n(l1FillEnable_n), .l2Hit(l2Hit), .l2Fill(l2Fill),
        .castout(castout), .sram_addr_bit2(sram_addr_bit2), .sram_addr_bit3A(sram_addr_bit3A),
        .sram_addr_bit3B(sram_addr_bit3B), .sram_output_enable_nA(sram_output_enable_nA),
        .sram_output_enable_nB(sram_output_enable_nB), .sram_write_enable_nA(sram_write_enable_nA),
        .sram_write_enable_nB(sram_write_enable_nB), .sram_chip_select(sram_chip_select));
    cpu_bus_model cpu_bus_model_inst (.sys_clk(sys_clk), .nrst(nrst), .busy(busy), .slow(slow),
        .beatDone(beatDone));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        d = regRdata;
    endtask
    // One CPU memory cycle; flags are {hit, fill, fill enable_n, castout}, compared under mask m.
    // Strobes are captured in every beat cycle, since a beat only marks the word that is on the pins.
    task automatic go(input logic [31:0] a, input logic [3:0] exp, input logic [3:0] m);
        int n;
        weS = '{default: 2'h3};
        @(posedge sys_clk);
        cycStart <= 1'b1;
        cpuAddr <= a;
        @(posedge sys_clk);
        cycStart <= 1'b0;
        @(negedge sys_clk);
        chk(8'({l2Hit, l2Fill, l1FillEnable_n, castout} & m), 8'(exp & m));
        csBusy = sram_chip_select;
        nBeats = 0;
        for (n = 0; n < 300 && busy; n++) begin
            if (beatDone && nBeats < 4) begin
                oeS[nBeats] = {sram_output_enable_nA, sram_output_enable_nB};
                weS[nBeats] = {sram_write_enable_nA, sram_write_enable_nB};
                adS[nBeats] = {sram_addr_bit3A, sram_addr_bit3B, sram_addr_bit2};
                nBeats++;
            end
            @(negedge sys_clk);
        end
        if (n == 300) chk(8'h01, 8'h00);
        // Ending on a rising edge lets callers change inputs right there.
        @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] ofs [6];
        logic [7:0] d;
        int i;
        ofs = '{l2_cache_pkg::SHADOW_CACHE_CONTROL_OFS, l2_cache_pkg::CACHE_FILL_CONFIG_OFS,
            l2_cache_pkg::MEMORY_DECODE_A_OFS, l2_cache_pkg::MEMORY_DECODE_B_OFS,
            l2_cache_pkg::SMM_CONTROL_OFS, l2_cache_pkg::CACHE_MODE_OFS};
        for (i = 0; i < 6; i++) begin
            rd(ofs[i], d);
            chk(d, l2_cache_pkg::REG_RESET);
            wr(ofs[i], 8'h5A + 8'(i));
            rd(ofs[i], d);
            chk(d, 8'h5A + 8'(i));
            wr(ofs[i], 8'h00);
        end
        wr(8'h40, 8'hFF);
        rd(8'h40, d);
        chk(d, 8'h00);
        rd(l2_cache_pkg::CACHE_STATUS_OFS, d);
        chk(d, 8'h10);
        clkEn <= 1'b0;
        wr(ofs[0], 8'hFF);
        clkEn <= 1'b1;
        rd(ofs[0], d);
        chk(d, 8'h00);
        $display("register test done");
    endtask
    task automatic t_policy;
        int p, d;
        logic f;
        wr(l2_cache_pkg::CACHE_MODE_OFS, 8'h04);
        tagDirty <= 1'b1;
        for (p = 0; p < 4; p++) begin
            for (d = 0; d < 2; d++) begin
                wr(l2_cache_pkg::CACHE_FILL_CONFIG_OFS, 8'(p << 6));
                dataCode <= d[0];
                f = (p == 0) || (p == 3) || (p == 1 && d == 0) || (p == 2 && d == 1);
                go(32'h0, {1'b0, f, 1'b0, f}, 4'hF);
            end
        end
        writeCycle <= 1'b1;
        go(32'h0, 4'h0, 4'h5);
        writeCycle <= 1'b0;
        tagDirty <= 1'b0;
        wr(l2_cache_pkg::CACHE_FILL_CONFIG_OFS, 8'h00);
        $display("fill policy test done");
    endtask
    task automatic t_hit;
        int k;
        logic [1:0] w;
        wr(l2_cache_pkg::CACHE_FILL_CONFIG_OFS, 8'h40);
        dataCode <= 1'b1;
        tagHit <= 1'b1;
        tagDirty <= 1'b1;
        slow <= 1'b1;
        go(32'h8, 4'h8, 4'hD);
        chk(8'(nBeats), 8'h04);
        chk(8'(csBusy), 8'h00);
        for (k = 0; k < 4; k++) begin
            w = 2'h2 ^ 2'(k);
            chk(8'({adS[k][2], adS[k][0]}), 8'(w));
            chk(8'(oeS[k][1]), 8'h00);
        end
        slow <= 1'b0;
        wr(l2_cache_pkg::CACHE_MODE_OFS, 8'h07);
        go(32'h8004, 4'h8, 4'hD);
        chk(8'(csBusy), 8'h01);
        chk(8'(sram_chip_select), 8'h00);
        for (k = 0; k < 4; k++) begin
            w = 2'h1 ^ 2'(k);
            chk(8'(oeS[k]), w[0] ? 8'h02 : 8'h01);
            chk(8'(adS[k][0]), 8'h01);
            chk(8'(w[0] ? adS[k][1] : adS[k][2]), 8'(w[1]));
        end
        wr(l2_cache_pkg::CACHE_MODE_OFS, 8'h04);
        shadowArea <= 1'b1;
        go(32'h0, 4'hA, 4'hE);
        shadowArea <= 1'b0;
        tagHit <= 1'b0;
        tagDirty <= 1'b0;
        wr(l2_cache_pkg::CACHE_FILL_CONFIG_OFS, 8'h00);
        $display("hit and strobe test done");
    endtask
    task automatic t_range;
        logic [7:0] md [4];
        int hb [4];
        int i;
        md = '{8'h04, 8'h0C, 8'h14, 8'h54};
        hb = '{22, 23, 25, 27};
        for (i = 0; i < 4; i++) begin
            wr(l2_cache_pkg::CACHE_MODE_OFS, md[i]);
            go(32'h1 << hb[i], 4'h4, 4'hF);
            go(32'h2 << hb[i], 4'h0, 4'hF);
        end
        wr(l2_cache_pkg::CACHE_MODE_OFS, 8'h04);
        $display("range test done");
    endtask
    task automatic t_shadow;
        shadowArea <= 1'b1;
        go(32'h0, 4'h2, 4'hF);
        wr(l2_cache_pkg::SHADOW_CACHE_CONTROL_OFS, 8'h08);
        go(32'h0, 4'h6, 4'hF);
        wr(l2_cache_pkg::SHADOW_CACHE_CONTROL_OFS, 8'h04);
        go(32'h0, 4'h0, 4'hF);
        writeCycle <= 1'b1;
        tagHit <= 1'b1;
        wr(l2_cache_pkg::SHADOW_CACHE_CONTROL_OFS, 8'h8C);
        go(32'h0, 4'h8, 4'h8);
        chk(8'(weS[0]), 8'h03);
        wr(l2_cache_pkg::SHADOW_CACHE_CONTROL_OFS, 8'h0C);
        go(32'h0, 4'h8, 4'h8);
        chk(8'(weS[0][1]), 8'h00);
        writeCycle <= 1'b0;
        tagHit <= 1'b0;
        shadowArea <= 1'b0;
        wr(l2_cache_pkg::SHADOW_CACHE_CONTROL_OFS, 8'h00);
        $display("shadow test done");
    endtask
    task automatic t_decode;
        localDram <= 1'b0;
        decodeHitA <= 1'b1;
        go(32'h0, 4'h2, 4'hF);
        wr(l2_cache_pkg::MEMORY_DECODE_A_OFS, 8'h01);
        go(32'h0, 4'h0, 4'hF);
        decodeHitA <= 1'b0;
        decodeHitB <= 1'b1;
        wr(l2_cache_pkg::MEMORY_DECODE_B_OFS, 8'h02);
        go(32'h0, 4'h0, 4'hF);
        decodeHitB <= 1'b0;
        localDram <= 1'b1;
        smmActive <= 1'b1;
        go(32'h0, 4'h2, 4'h2);
        wr(l2_cache_pkg::SMM_CONTROL_OFS, 8'h08);
        go(32'h0, 4'h0, 4'h2);
        $display("decode test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        failures++;
        end_of_test;
    end
    initial begin
        {failures, n_compared} = '0;
        {nrst, regWr, regRd, cycStart, writeCycle, dataCode, smmActive, shadowArea} = '0;
        {decodeHitA, decodeHitB, tagHit, tagDirty, slow} = '0;
        {clkEn, memCycle, localDram} = 3'h7;
        regAddr = 8'h00;
        regWdata = 8'h00;
        cpuAddr = 32'h0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(8'(l1FillEnable_n), 8'h01);
        chk(8'(sram_chip_select), 8'h01);
        t_regs;
        t_policy;
        t_hit;
        t_range;
        t_shadow;
        t_decode;
        end_of_test;
    end
endmodule
